// [src/egress_acl_block_consts.svh]
// Constants for the egress ACL key and action block
`ifndef EGRESS_ACL_BLOCK_CONSTS_SVH
`define EGRESS_ACL_BLOCK_CONSTS_SVH
`define EGRESS_ACL_BLOCK_ETHERTYPE_FIELD_IPV4     16'h0800
`define EGRESS_ACL_BLOCK_ETHERTYPE_FIELD_IPV6     16'h86DD
`define EGRESS_ACL_BLOCK_ETHERTYPE_FIELD_ARP      16'h0806
`define EGRESS_ACL_BLOCK_ETHERTYPE_FIELD_RARP     16'h8035
`define EGRESS_ACL_BLOCK_ETHERTYPE_FIELD_OAM      16'h8902
`define EGRESS_ACL_BLOCK_ETHERTYPE_FIELD_MIN      16'h0600
`define EGRESS_ACL_BLOCK_SAP_SNAP       8'hAA
`define EGRESS_ACL_BLOCK_CTRL_SNAP      8'h03
`define EGRESS_ACL_BLOCK_PROTO_TCP      8'h06
`define EGRESS_ACL_BLOCK_PROTO_UDP      8'h11
`define EGRESS_ACL_BLOCK_IPV4_PAYLOAD_OFS 20
`define EGRESS_ACL_BLOCK_PROF_VIF_BASE  8'h41
`define EGRESS_ACL_BLOCK_PROF_CPU_BASE  8'h82
`define EGRESS_ACL_BLOCK_NUM_QUEUE_VIRTUAL_PORT      256
`define EGRESS_ACL_BLOCK_NUM_PROF       138
`define EGRESS_ACL_BLOCK_NUM_RNG        16
`define EGRESS_ACL_BLOCK_ADDR_MAP       12'h000
`define EGRESS_ACL_BLOCK_ADDR_PROF      12'h400
`define EGRESS_ACL_BLOCK_ADDR_RNG_CTRL  12'h640
`define EGRESS_ACL_BLOCK_ADDR_RNG_LO    12'h680
`define EGRESS_ACL_BLOCK_ADDR_RNG_HI    12'h6C0
`define EGRESS_ACL_BLOCK_ADDR_STATUS    12'h700
`endif

// [src/egress_acl_block_pkg.sv]
// Types for the egress ACL key and action block
package egress_acl_block_pkg;
	typedef enum logic [2:0] {
		EGRESS_ACL_BLOCK_FT_ETHERTYPE_FIELD = 3'h0, EGRESS_ACL_BLOCK_FT_IPV4 = 3'h1, EGRESS_ACL_BLOCK_FT_IPV6 = 3'h2, EGRESS_ACL_BLOCK_FT_ARP = 3'h3,
		EGRESS_ACL_BLOCK_FT_OAM = 3'h4, EGRESS_ACL_BLOCK_FT_SNAP = 3'h5, EGRESS_ACL_BLOCK_FT_LLC = 3'h6
	} egress_acl_block_ftype_type;
	typedef enum logic [2:0] {
		EGRESS_ACL_BLOCK_KEY_MAC = 3'h0, EGRESS_ACL_BLOCK_KEY_ARP = 3'h1, EGRESS_ACL_BLOCK_KEY_VID = 3'h2, EGRESS_ACL_BLOCK_KEY_7TUP = 3'h3,
		EGRESS_ACL_BLOCK_KEY_L4 = 3'h4, EGRESS_ACL_BLOCK_KEY_IPOTH = 3'h5
	} egress_acl_block_key_type;
	typedef enum logic [1:0] {
		EGRESS_ACL_BLOCK_FWD = 2'h0, EGRESS_ACL_BLOCK_DISCARD = 2'h1, EGRESS_ACL_BLOCK_REDIRECT = 2'h2, EGRESS_ACL_BLOCK_COPY = 2'h3
	} egress_acl_block_fwd_type;
	// Action word, first field at bit 0 (packed structs list MSB first)
	typedef struct packed {
		logic         ignore_pipeline;
		logic [10:0]  hit_counter_index;
		logic [2:0]   rewriter_command;
		logic [5:0]   policer_index;
		logic         policer_yellow_mark;
		logic         policer_enable;
		logic [2:0]   cpu_queue;
		logic         cpu_copy;
		logic [1:0]   mirror_probe_select;
		logic [6:0]   copy_port;
		logic [15:0]  copy_queue;
		logic [1:0]   forward_selector;
		logic         hit_interrupt_enable;
		logic         single_hit_cpu_copy;
	} egress_acl_block_action_type;
	typedef struct packed {
		logic         valid;
		logic [7:0]   queue_virtual_port;
		logic         to_cpu;
		logic [2:0]   cpu_dest;
		logic [15:0]  type_len;
		logic [3:0]   ip_version;
		logic [7:0]   ip_protocol_field;
		logic [7:0]   dsap;
		logic [7:0]   ssap;
		logic [7:0]   llc_ctrl;
		logic [15:0]  sport;
		logic [15:0]  dport;
		logic [15:0]  custom;
		logic [31:0]  tcp_seq;
		logic [2:0]   mel;
		logic [11:0]  class_vid;
		logic [5:0]   class_dscp;
		logic [255:0] ip_bytes;
	} egress_acl_block_frame_type;
	typedef struct packed {
		logic         valid;
		logic [2:0]   ftype;
		logic [7:0]   profile;
		logic [7:0]   port_or_if;
		logic [7:0]   vif_id;
		logic [7:0]   acl_group;
		logic [1:0]   lookup_enable;
		logic [5:0]   key_sel;
		logic         ipv4;
		logic         transport_tcp_or_udp_flag;
		logic         tcp;
		logic [15:0]  ethertype_field;
		logic         oam_ethertype_flag;
		logic [7:0]   ip_protocol_field;
		logic [15:0]  dest_port_field;
		logic [15:0]  src_port;
		logic [15:0]  range_match_mask;
		logic         ports_equal_flag;
		logic         seq_zero_flag;
		logic [95:0]  after_ip_payload_bytes;
		logic [63:0]  after_transport_payload_bytes;
	} egress_acl_block_key_out_type;
	typedef struct packed {
		logic         valid;
		logic         discard;
		logic         redirect;
		logic         copy;
		logic [15:0]  dest_queue;
		logic [6:0]   dest_port;
		logic [1:0]   mirror_probe;
		logic         cpu_copy;
		logic [2:0]   cpu_queue;
		logic         police;
		logic         police_yellow;
		logic [5:0]   policer_index;
		logic [2:0]   rewriter_command;
		logic         count;
		logic [10:0]  hit_counter_index;
	} egress_acl_block_result_type;
endpackage : egress_acl_block_pkg

// [src/egress_acl_block_top.sv]
// Egress ACL classification, key building and action decoding
//
// Behaviour
// - Transport flag on protocol 6 or 17; TCP flag only on 6.
// - Seven-tuple key: non-TRANSPORT_TCP_OR_UDP_FLAG IP puts protocol in destination port field.
// - 16-bit range mask; VID/DSCP from classification, ports/custom from frame.
// - Ports-equal flag when ports match; sequence-zero flag when TCP sequence is 0.
// - No IPv4 option parsing; IP payload always starts 20 bytes into IPv4 header, TCP/UDP transport payload 24 bytes in.
// - OAM flag on 0x8902; ethertype field then carries MEL flags.
// - Single-hit copies next match to CPU queue; CPU-copy copies every match.
// - Hit on rule with interrupt-enable bit raises an interrupt.
// - Forward selector: 0 forward, 1 discard, 2 redirect, 3 copy.
// - Redirect or copy use action queue and port as destination.
// - Mirror probe inserted only for copy; 0 none, 1..3 probes 0..2.
// - Policing by 6-bit index; remark marks yellow instead of discarding.
// - 3-bit rewriter command passed on: none, MAC swap, DMAC translation.
// - 11-bit counter index of each lookup addresses the match counters.
// - Virtual port maps to port/interface, VIF id, ACL group; bit selects source.
// - Profiles: ports 0-64, interfaces 65-129, CPU destinations 130-137.
// - Each lookup generates a key and uses a match only when enabled.
// - IPv6 on 0x86DD version 6, IPv4 on 0x800 version 4; then TRANSPORT_TCP_OR_UDP_FLAG/other.
// - 0x0806/0x8035 are ARP family, 0x8902 is OAM.
// - Below 0x600 SNAP if AA/AA/03 else LLC; other values generic ethertype.
// - OAM/SNAP/LLC/generic use MAC key; ARP ARP or MAC; IP many.
// - Range checkers match inclusively between start and end.
//
// Implementation choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "egress_acl_block_consts.svh"

module egress_acl_block_top
	import egress_acl_block_pkg::*;
#(
	parameter int NUM_RNG = `EGRESS_ACL_BLOCK_NUM_RNG
) (
	input  wire logic             i_clk_sys,
	input  wire logic             i_rst_n,
	input  wire logic [11:0]      i_reg_addr,
	input  wire logic [31:0]      i_reg_wdata,
	input  wire logic             i_reg_wr,
	input  wire logic             i_reg_rd,
	output logic [31:0]           o_reg_rdata,
	input  wire egress_acl_block_frame_type   i_frame,
	input  wire logic [1:0]       i_hit,
	input  wire egress_acl_block_action_type  i_action0,
	input  wire egress_acl_block_action_type  i_action1,
	output egress_acl_block_key_out_type      o_key,
	output egress_acl_block_result_type       o_result0,
	output egress_acl_block_result_type       o_result1,
	output logic                  o_hit_irq
);
	if (NUM_RNG != `EGRESS_ACL_BLOCK_NUM_RNG) begin : g_bad_rng
		$error("range mask is 16 bits wide");
	end

	// Configuration memories
	logic [24:0] map_mem [`EGRESS_ACL_BLOCK_NUM_QUEUE_VIRTUAL_PORT];
	logic [7:0]  prof_mem [`EGRESS_ACL_BLOCK_NUM_PROF];
	logic [2:0]  rng_ctrl [NUM_RNG];
	logic [15:0] rng_lo [NUM_RNG];
	logic [15:0] rng_hi [NUM_RNG];
	logic [1:0]  single_done_ff;
	logic [31:0] rdata_ff;

	wire sel_map  = i_reg_addr[11:10] == 2'h0;
	wire sel_prof = i_reg_addr >= `EGRESS_ACL_BLOCK_ADDR_PROF && i_reg_addr < `EGRESS_ACL_BLOCK_ADDR_RNG_CTRL;
	wire sel_rc   = i_reg_addr[11:6] == 6'(`EGRESS_ACL_BLOCK_ADDR_RNG_CTRL >> 6);
	wire sel_rlo  = i_reg_addr[11:6] == 6'(`EGRESS_ACL_BLOCK_ADDR_RNG_LO >> 6);
	wire sel_rhi  = i_reg_addr[11:6] == 6'(`EGRESS_ACL_BLOCK_ADDR_RNG_HI >> 6);
	wire sel_st   = i_reg_addr == `EGRESS_ACL_BLOCK_ADDR_STATUS;
	wire [7:0] map_idx  = i_reg_addr[9:2];
	// Profile window reaches past 0x600 so the CPU profiles stay writable
	wire [9:0] prof_byte = 10'(i_reg_addr - `EGRESS_ACL_BLOCK_ADDR_PROF);
	wire [7:0] prof_ofs = prof_byte[9:2];
	wire       prof_ok  = prof_ofs < 8'(`EGRESS_ACL_BLOCK_NUM_PROF);
	wire [3:0] rng_idx  = i_reg_addr[5:2];

	always_ff @(posedge i_clk_sys) begin
		if (i_reg_wr && sel_map)
			map_mem[map_idx] <= i_reg_wdata[24:0];
		if (i_reg_wr && sel_prof && prof_ok)
			prof_mem[prof_ofs[7:0]] <= i_reg_wdata[7:0];
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			for (int r = 0; r < NUM_RNG; r++) begin
				rng_ctrl[r] <= 3'h0;
				rng_lo[r] <= 16'h0000;
				rng_hi[r] <= 16'h0000;
			end
		end else if (i_reg_wr) begin
			if (sel_rc)
				rng_ctrl[rng_idx] <= i_reg_wdata[2:0];
			if (sel_rlo)
				rng_lo[rng_idx] <= i_reg_wdata[15:0];
			if (sel_rhi)
				rng_hi[rng_idx] <= i_reg_wdata[15:0];
		end
	end

	// Read path; map and profile memories have no reset so their contents read as written
	logic [31:0] nxt_rdata;
	always_comb begin
		nxt_rdata = 32'h0000_0000;
		if (sel_map)
			nxt_rdata = {7'h00, map_mem[map_idx]};
		else if (sel_prof && prof_ok)
			nxt_rdata = {24'h000000, prof_mem[prof_ofs[7:0]]};
		else if (sel_rc)
			nxt_rdata = {29'h0, rng_ctrl[rng_idx]};
		else if (sel_rlo)
			nxt_rdata = {16'h0000, rng_lo[rng_idx]};
		else if (sel_rhi)
			nxt_rdata = {16'h0000, rng_hi[rng_idx]};
		else if (sel_st)
			nxt_rdata = {30'h0, single_done_ff};
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n)
			rdata_ff <= 32'h0000_0000;
		else if (i_reg_rd)
			rdata_ff <= nxt_rdata;
	end
	assign o_reg_rdata = rdata_ff;

	// Interface map: [7:0] port, [15:8] interface, [23:16] ACL group, [24] use interface
	wire [24:0] map_ent  = map_mem[i_frame.queue_virtual_port];
	wire        use_if   = map_ent[24];
	wire [7:0]  port_num = use_if ? map_ent[15:8] : map_ent[7:0];
	wire [7:0]  profile  = i_frame.to_cpu ? `EGRESS_ACL_BLOCK_PROF_CPU_BASE + {5'h00, i_frame.cpu_dest}
		: use_if ? `EGRESS_ACL_BLOCK_PROF_VIF_BASE + map_ent[15:8] : map_ent[7:0];
	// Profile: [1:0] lookup enables, [4:2] lookup0 IP key, [5] lookup0 ARP key, [7:6] lookup1
	wire [7:0]  prof_ent = prof_mem[profile];

	// Frame type classification
	wire [15:0] tl      = i_frame.type_len;
	wire        is_ip6  = tl == `EGRESS_ACL_BLOCK_ETHERTYPE_FIELD_IPV6 && i_frame.ip_version == 4'h6;
	wire        is_ip4  = tl == `EGRESS_ACL_BLOCK_ETHERTYPE_FIELD_IPV4 && i_frame.ip_version == 4'h4;
	wire        is_arp  = tl == `EGRESS_ACL_BLOCK_ETHERTYPE_FIELD_ARP || tl == `EGRESS_ACL_BLOCK_ETHERTYPE_FIELD_RARP;
	wire        is_oam  = tl == `EGRESS_ACL_BLOCK_ETHERTYPE_FIELD_OAM;
	wire        is_llcf = tl < `EGRESS_ACL_BLOCK_ETHERTYPE_FIELD_MIN;
	wire        is_snap = is_llcf && i_frame.dsap == `EGRESS_ACL_BLOCK_SAP_SNAP
		&& i_frame.ssap == `EGRESS_ACL_BLOCK_SAP_SNAP && i_frame.llc_ctrl == `EGRESS_ACL_BLOCK_CTRL_SNAP;
	wire        is_ip   = is_ip4 || is_ip6;
	wire [7:0]  proto   = i_frame.ip_protocol_field;
	wire        is_tcp  = is_ip && proto == `EGRESS_ACL_BLOCK_PROTO_TCP;
	wire        is_l4   = is_tcp || (is_ip && proto == `EGRESS_ACL_BLOCK_PROTO_UDP);
	egress_acl_block_ftype_type ftype;
	always_comb begin
		ftype = EGRESS_ACL_BLOCK_FT_ETHERTYPE_FIELD;
		if (is_ip6)
			ftype = EGRESS_ACL_BLOCK_FT_IPV6;
		else if (is_ip4)
			ftype = EGRESS_ACL_BLOCK_FT_IPV4;
		else if (is_arp)
			ftype = EGRESS_ACL_BLOCK_FT_ARP;
		else if (is_oam)
			ftype = EGRESS_ACL_BLOCK_FT_OAM;
		else if (is_snap)
			ftype = EGRESS_ACL_BLOCK_FT_SNAP;
		else if (is_llcf)
			ftype = EGRESS_ACL_BLOCK_FT_LLC;
	end

	// Key selection per lookup: only IP and ARP frames may leave the MAC key
	function automatic logic [2:0] key_pick(input logic [2:0] ip_sel, input logic arp_sel);
		key_pick = EGRESS_ACL_BLOCK_KEY_MAC;
		if (is_ip)
			key_pick = ip_sel <= 3'(EGRESS_ACL_BLOCK_KEY_IPOTH) && ip_sel != 3'(EGRESS_ACL_BLOCK_KEY_ARP)
				? ip_sel : 3'(EGRESS_ACL_BLOCK_KEY_MAC);
		else if (is_arp && arp_sel)
			key_pick = EGRESS_ACL_BLOCK_KEY_ARP;
	endfunction : key_pick
	wire [2:0] key0 = key_pick(prof_ent[4:2], prof_ent[5]);
	wire [2:0] key1 = key_pick({1'b0, prof_ent[7:6]} + 3'h2, prof_ent[6]);

	// Range checkers: 0 dport, 1 sport, 2 either port, 3 VID, 4 DSCP, 5 custom
	logic [NUM_RNG-1:0] rng_hit;
	generate
		for (genvar g = 0; g < NUM_RNG; g++) begin : g_rng
			function automatic logic in_rng(input logic [15:0] v);
				in_rng = v >= rng_lo[g] && v <= rng_hi[g];
			endfunction : in_rng
			always_comb begin
				unique case (rng_ctrl[g])
					3'h0: rng_hit[g] = is_l4 && in_rng(i_frame.dport);
					3'h1: rng_hit[g] = is_l4 && in_rng(i_frame.sport);
					3'h2: rng_hit[g] = is_l4 && (in_rng(i_frame.sport) || in_rng(i_frame.dport));
					3'h3: rng_hit[g] = in_rng({4'h0, i_frame.class_vid});
					3'h4: rng_hit[g] = is_ip && in_rng({10'h000, i_frame.class_dscp});
					3'h5: rng_hit[g] = in_rng(i_frame.custom);
					default: rng_hit[g] = 1'b0;
				endcase
			end
		end
	endgenerate

	// MEL flags: one bit per level above zero
	wire [6:0] mel_flags = 7'((8'h01 << i_frame.mel) - 8'h01);
	// IPv4 payload is taken at a fixed 20-byte offset, options are never parsed
	wire [95:0] ip_pay = i_frame.ip_bytes[255-`EGRESS_ACL_BLOCK_IPV4_PAYLOAD_OFS*8 -: 96];

	egress_acl_block_key_out_type key_ff;
	egress_acl_block_key_out_type nxt_key;
	always_comb begin
		nxt_key = '0;
		nxt_key.valid = i_frame.valid;
		nxt_key.ftype = ftype;
		nxt_key.profile = profile;
		nxt_key.port_or_if = port_num;
		nxt_key.vif_id = map_ent[15:8];
		nxt_key.acl_group = map_ent[23:16];
		nxt_key.lookup_enable = prof_ent[1:0];
		nxt_key.key_sel = {key1, key0};
		nxt_key.ipv4 = is_ip4;
		nxt_key.transport_tcp_or_udp_flag = is_l4;
		nxt_key.tcp = is_tcp;
		nxt_key.oam_ethertype_flag = is_oam;
		nxt_key.ethertype_field = is_oam ? {9'h000, mel_flags} : tl;
		nxt_key.ip_protocol_field = proto;
		nxt_key.dest_port_field = is_l4 ? i_frame.dport
			: is_ip ? {8'h00, proto} : 16'h0000;
		nxt_key.src_port = is_l4 ? i_frame.sport : 16'h0000;
		nxt_key.range_match_mask = rng_hit;
		nxt_key.ports_equal_flag = is_l4 && i_frame.sport == i_frame.dport;
		nxt_key.seq_zero_flag = is_tcp && i_frame.tcp_seq == 32'h0000_0000;
		nxt_key.after_ip_payload_bytes = ip_pay;
		nxt_key.after_transport_payload_bytes = is_l4 ? i_frame.ip_bytes[63:0]
			: ip_pay[95:32];
	end

	// Action decode for each lookup
	egress_acl_block_result_type res_ff [2];
	egress_acl_block_result_type nxt_res [2];
	logic [1:0] irq_raw;
	logic [1:0] nxt_done;
	generate
		for (genvar l = 0; l < 2; l++) begin : g_act
			egress_acl_block_action_type a;
			assign a = l == 0 ? i_action0 : i_action1;
			wire used = i_frame.valid && prof_ent[l] && i_hit[l];
			wire once = a.single_hit_cpu_copy && !single_done_ff[l];
			assign irq_raw[l] = used && a.hit_interrupt_enable;
			assign nxt_done[l] = single_done_ff[l] | (used && once);
			always_comb begin
				nxt_res[l] = '0;
				nxt_res[l].valid = used;
				nxt_res[l].discard = used && a.forward_selector == EGRESS_ACL_BLOCK_DISCARD;
				nxt_res[l].redirect = used && a.forward_selector == EGRESS_ACL_BLOCK_REDIRECT;
				nxt_res[l].copy = used && a.forward_selector == EGRESS_ACL_BLOCK_COPY;
				if (used && a.forward_selector[1]) begin
					nxt_res[l].dest_queue = a.copy_queue;
					nxt_res[l].dest_port = a.copy_port;
				end
				if (used && a.forward_selector == EGRESS_ACL_BLOCK_COPY)
					nxt_res[l].mirror_probe = a.mirror_probe_select;
				nxt_res[l].cpu_copy = used && (a.cpu_copy || once);
				nxt_res[l].cpu_queue = a.cpu_queue;
				nxt_res[l].police = used && a.policer_enable;
				nxt_res[l].police_yellow = used && a.policer_enable && a.policer_yellow_mark;
				nxt_res[l].policer_index = a.policer_index;
				nxt_res[l].rewriter_command = used ? a.rewriter_command : 3'h0;
				nxt_res[l].count = used;
				nxt_res[l].hit_counter_index = a.hit_counter_index;
			end
		end
	endgenerate

	// Single-hit state is one bit per lookup; writing 1 to the status word re-arms it unless a single-hit copy sets it in the same cycle
	wire [1:0] rearm = (i_reg_wr && sel_st) ? i_reg_wdata[1:0] : 2'h0;
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			key_ff <= '0;
			res_ff[0] <= '0;
			res_ff[1] <= '0;
			o_hit_irq <= 1'b0;
			single_done_ff <= 2'h0;
		end else begin
			key_ff <= nxt_key;
			res_ff[0] <= nxt_res[0];
			res_ff[1] <= nxt_res[1];
			o_hit_irq <= |irq_raw;
			single_done_ff <= nxt_done & ~(rearm & ~(nxt_done ^ single_done_ff));
		end
	end
	assign o_key = key_ff;
	assign o_result0 = res_ff[0];
	assign o_result1 = res_ff[1];
endmodule : egress_acl_block_top

// [test/eaka_top_props.sv]
// Port-level properties of the egress ACL block
`timescale 1ns/1ps
module eaka_props
	import egress_acl_block_pkg::*;
(
	input wire logic             i_clk_sys,
	input wire logic             i_rst_n,
	input wire egress_acl_block_frame_type   i_frame,
	input wire logic [1:0]       i_hit,
	input wire egress_acl_block_action_type  i_action0,
	input wire egress_acl_block_action_type  i_action1,
	input wire egress_acl_block_key_out_type o_key,
	input wire egress_acl_block_result_type  o_result0,
	input wire egress_acl_block_result_type  o_result1,
	input wire logic             o_hit_irq
);
	wire ip4_in = i_frame.valid && i_frame.type_len == 16'h0800 && i_frame.ip_version == 4'h4;
	wire ip6_in = i_frame.valid && i_frame.type_len == 16'h86DD && i_frame.ip_version == 4'h6;
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rst_n);
	property p_tcp;
		ip4_in && i_frame.ip_protocol_field == 8'h06
			|=> o_key.tcp && o_key.transport_tcp_or_udp_flag;
	endproperty
	a_tcp: assert property (p_tcp) else $error("tcp flags missing");
	property p_udp;
		ip6_in && i_frame.ip_protocol_field == 8'h11
			|=> o_key.transport_tcp_or_udp_flag && !o_key.tcp;
	endproperty
	a_udp: assert property (p_udp) else $error("udp flags wrong");
	property p_zero;
		ip4_in && i_frame.ip_protocol_field == 8'h06 && i_frame.tcp_seq == 32'h0
			&& i_frame.sport == i_frame.dport |=> o_key.seq_zero_flag && o_key.ports_equal_flag;
	endproperty
	a_zero: assert property (p_zero) else $error("port or sequence flag missing");
	property p_oam;
		i_frame.valid && i_frame.type_len == 16'h8902
			|=> o_key.oam_ethertype_flag && o_key.ftype == EGRESS_ACL_BLOCK_FT_OAM;
	endproperty
	a_oam: assert property (p_oam) else $error("maintenance frame not flagged");
	property p_fwd;
		o_result0.valid |-> o_result0.copy == ($past(i_action0.forward_selector) == 2'h3)
			&& o_result0.discard == ($past(i_action0.forward_selector) == 2'h1)
			&& o_result0.redirect == ($past(i_action0.forward_selector) == 2'h2);
	endproperty
	a_fwd: assert property (p_fwd) else $error("forward decode wrong");
	property p_dest;
		o_result0.redirect || o_result0.copy |-> o_result0.dest_queue == $past(i_action0.copy_queue)
			&& o_result0.dest_port == $past(i_action0.copy_port);
	endproperty
	a_dest: assert property (p_dest) else $error("destination wrong");
	property p_mirror;
		o_result0.valid && !o_result0.copy |-> o_result0.mirror_probe == 2'h0;
	endproperty
	a_mirror: assert property (p_mirror) else $error("probe outside copy");
	property p_irq;
		o_hit_irq == (o_result0.valid && $past(i_action0.hit_interrupt_enable)
			|| o_result1.valid && $past(i_action1.hit_interrupt_enable));
	endproperty
	a_irq: assert property (p_irq) else $error("hit interrupt wrong");
	property p_off;
		!$past(i_hit[1]) |-> !o_result1.valid;
	endproperty
	a_off: assert property (p_off) else $error("result without hit");
endmodule : eaka_props

// [test/eaka_queue_model.sv]
// Queue-side source model: hands frame copies and lookup answers to the block
`timescale 1ns/1ps
module eaka_queue_model
	import egress_acl_block_pkg::*;
(
	input  wire logic            i_clk_sys,
	input  wire logic            i_rst_n,
	input  wire egress_acl_block_frame_type  i_req,
	input  wire egress_acl_block_action_type i_act0_req,
	input  wire egress_acl_block_action_type i_act1_req,
	output egress_acl_block_frame_type       o_frame,
	output egress_acl_block_action_type      o_action0,
	output egress_acl_block_action_type      o_action1
);
	egress_acl_block_frame_type last_ff;
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) last_ff <= '0;
		else if (i_req.valid) last_ff <= i_req;
	end
	// Idle fields show the inverse of the last copy, so stale data never looks current
	assign o_frame = i_req.valid ? i_req : {1'b0, ~last_ff[$bits(egress_acl_block_frame_type)-2:0]};
	assign o_action0 = i_act0_req;
	assign o_action1 = i_act1_req;
endmodule : eaka_queue_model

// [test/egress_acl_key_action_bench.sv]
// Self-checking bench for the egress ACL key and action block
`timescale 1ns/1ps
module egress_acl_key_action_bench
	import egress_acl_block_pkg::*;
;
	logic             i_clk_sys = 1'b0;
	logic             i_rst_n = 1'b0;
	logic [11:0]      addr = 12'h000;
	logic [31:0]      wdata = 32'h0000_0000;
	logic             wr = 1'b0;
	logic             rd = 1'b0;
	logic [31:0]      rdata;
	logic [1:0]       hit = 2'h0;
	egress_acl_block_frame_type   req = '0;
	egress_acl_block_frame_type   frame;
	egress_acl_block_frame_type   f = '0;
	egress_acl_block_action_type  a0 = '0;
	egress_acl_block_action_type  a1 = '0;
	egress_acl_block_action_type  x0 = '0;
	egress_acl_block_action_type  x1 = '0;
	egress_acl_block_action_type  act0;
	egress_acl_block_action_type  act1;
	egress_acl_block_key_out_type key;
	egress_acl_block_result_type  r0;
	egress_acl_block_result_type  r1;
	logic             irq;
	int               n_mismatch = 0;
	int               comparisons = 0;
	logic [15:0]      tl_t [8] = '{16'h0800, 16'h86DD, 16'h0806, 16'h8035, 16'h8902, 16'h0050,
		16'h0050, 16'h9000};
	egress_acl_block_ftype_type   ft_t [8] = '{EGRESS_ACL_BLOCK_FT_IPV4, EGRESS_ACL_BLOCK_FT_IPV6, EGRESS_ACL_BLOCK_FT_ARP, EGRESS_ACL_BLOCK_FT_ARP,
		EGRESS_ACL_BLOCK_FT_OAM, EGRESS_ACL_BLOCK_FT_SNAP, EGRESS_ACL_BLOCK_FT_LLC, EGRESS_ACL_BLOCK_FT_ETHERTYPE_FIELD};
	always #50 i_clk_sys = ~i_clk_sys;
	eaka_queue_model u_eaka_queue_model (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_req(req),
		.i_act0_req(a0), .i_act1_req(a1), .o_frame(frame), .o_action0(act0), .o_action1(act1));
	egress_acl_block_top u_egress_acl_block_top (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_reg_addr(addr),
		.i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_frame(frame),
		.i_hit(hit), .i_action0(act0), .i_action1(act1), .o_key(key), .o_result0(r0),
		.o_result1(r1), .o_hit_irq(irq));
	task automatic chk(input logic [95:0] got, input logic [95:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wreg(input logic [11:0] a, input logic [31:0] d);
		@(posedge i_clk_sys);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge i_clk_sys);
		wr <= 1'b0;
	endtask : wreg
	task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
		@(posedge i_clk_sys);
		addr <= a;
		rd <= 1'b1;
		@(posedge i_clk_sys);
		rd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask : rchk
	// Frame and hits are held one cycle, actions stay driven; results are read just after the capture edge
	task automatic send(input logic [1:0] h);
		@(posedge i_clk_sys);
		req <= f;
		hit <= h;
		a0 <= x0;
		a1 <= x1;
		@(posedge i_clk_sys);
		req.valid <= 1'b0;
		hit <= 2'h0;
		#1;
	endtask : send
	task automatic base(input logic [15:0] tl, input logic [7:0] pr);
		f = '0;
		f.valid = 1'b1;
		f.queue_virtual_port = 8'h03;
		f.type_len = tl;
		f.ip_version = (tl == 16'h86DD) ? 4'h6 : 4'h4;
		f.ip_protocol_field = pr;
		f.sport = 16'h0050;
		f.dport = 16'h0050;
		f.tcp_seq = 32'h0000_0001;
		f.class_vid = 12'h00A;
		for (int i = 0; i < 32; i++) f.ip_bytes[8*i +: 8] = 8'(i + 8'h40);
	endtask : base
	task automatic t_regs();
		wreg(12'h00C, 32'h0109_0705);
		wreg(12'h010, 32'h0009_0705);
		wreg(12'h520, 32'h0000_000F);
		wreg(12'h414, 32'h0000_000D);
		wreg(12'h614, 32'h0000_0001);
		wreg(12'h680, 32'h0000_0050);
		wreg(12'h6C0, 32'h0000_0060);
		wreg(12'h644, 32'h0000_0003);
		wreg(12'h684, 32'h0000_000A);
		wreg(12'h6C4, 32'h0000_000A);
		rchk(12'h6C0, 32'h0000_0060);
		rchk(12'h614, 32'h0000_0001);
		rchk(12'hFFC, 32'h0000_0000);
		$display("register test done");
	endtask : t_regs
	task automatic t_class();
		for (int i = 0; i < 8; i++) begin
			base(tl_t[i], (i == 0) ? 8'h06 : 8'h11);
			f.dsap = 8'hAA;
			f.ssap = 8'hAA;
			f.llc_ctrl = (i == 6) ? 8'h04 : 8'h03;
			f.mel = 3'h3;
			send(2'h0);
			chk(key.ftype, ft_t[i]);
			chk({key.tcp, key.transport_tcp_or_udp_flag}, {i == 0, i < 2});
			chk({key.oam_ethertype_flag, key.ethertype_field},
				(i == 4) ? 17'h10007 : {1'b0, tl_t[i]});
			chk({key.profile, key.port_or_if, key.acl_group}, {8'h41 + 8'h07, 16'h0709});
			chk({key.lookup_enable, key.key_sel}, (i < 2) ? 8'hD3 : 8'hC0);
		end
		$display("classification test done");
	endtask : t_class
	task automatic t_fields();
		base(16'h0800, 8'h06);
		f.tcp_seq = 32'h0000_0000;
		send(2'h0);
		chk({key.ports_equal_flag, key.seq_zero_flag}, 2'h3);
		chk(key.range_match_mask, 16'h0003);
		base(16'h0800, 8'h06);
		f.dport = 16'h0061;
		send(2'h0);
		chk({key.ports_equal_flag, key.seq_zero_flag}, 2'h0);
		chk(key.range_match_mask, 16'h0002);
		base(16'h0800, 8'h2F);
		f.dport = 16'h0055;
		send(2'h0);
		chk(key.dest_port_field, 16'h002F);
		chk({key.ipv4, key.ip_protocol_field, key.src_port}, {1'b1, 8'h2F, 16'h0000});
		chk(key.range_match_mask, 16'h0002);
		chk(key.after_ip_payload_bytes, f.ip_bytes[95:0]);
		chk(key.after_transport_payload_bytes, f.ip_bytes[95:32]);
		$display("key field test done");
	endtask : t_fields
	task automatic t_actions();
		base(16'h0800, 8'h06);
		for (int i = 0; i < 4; i++) begin
			x0 = '0;
			x0.forward_selector = i[1:0];
			x0.copy_queue = 16'hBEE0 + 16'(i);
			x0.copy_port = 7'h15;
			x0.mirror_probe_select = 2'h2;
			x0.policer_enable = i[0];
			x0.policer_yellow_mark = 1'b1;
			x0.policer_index = 6'h2A;
			x0.rewriter_command = 3'(i % 3);
			x0.hit_counter_index = 11'h7F0 + 11'(i);
			x0.hit_interrupt_enable = i[1];
			send(2'h1);
			chk({r0.valid, r0.discard, r0.redirect, r0.copy}, {1'b1, i == 1, i == 2, i == 3});
			if (i > 1) chk({r0.dest_queue, r0.dest_port}, {x0.copy_queue, 7'h15});
			chk(r0.mirror_probe, (i == 3) ? 2'h2 : 2'h0);
			if (i[0]) chk({r0.police, r0.police_yellow, r0.policer_index}, 8'hEA);
			chk(r0.rewriter_command, 3'(i % 3));
			chk({r0.count, r0.hit_counter_index}, {1'b1, 11'h7F0 + 11'(i)});
			chk({irq, r1.valid}, {i[1], 1'b0});
		end
		$display("action test done");
	endtask : t_actions
	task automatic t_disabled();
		base(16'h0800, 8'h06);
		f.queue_virtual_port = 8'h04;
		x0 = '0;
		x1 = '0;
		x1.hit_interrupt_enable = 1'b1;
		send(2'h3);
		chk(key.profile, 8'h05);
		chk({r0.valid, r1.valid, irq}, 3'h4);
		chk({key.port_or_if, key.vif_id}, 16'h0507);
		f.to_cpu = 1'b1;
		f.cpu_dest = 3'h3;
		send(2'h3);
		chk({key.profile, r0.valid, r1.valid}, 10'h216);
		$display("disabled lookup test done");
	endtask : t_disabled
	task automatic t_single();
		base(16'h0800, 8'h06);
		x0 = '0;
		x1 = '0;
		x0.single_hit_cpu_copy = 1'b1;
		x0.cpu_queue = 3'h5;
		for (int i = 0; i < 5; i++) begin
			if (i == 2) begin
				rchk(12'h700, 32'h0000_0001);
				wreg(12'h700, 32'h0000_0001);
			end
			if (i == 3) x0.cpu_copy = 1'b1;
			send(2'h1);
			chk(r0.cpu_copy, i != 1);
			if (i != 1) chk(r0.cpu_queue, 3'h5);
		end
		$display("single hit test done");
	endtask : t_single
	// Mid-run reset: outputs, range setup and single-hit state must all clear
	task automatic t_reset();
		@(posedge i_clk_sys);
		i_rst_n <= 1'b0;
		@(posedge i_clk_sys);
		#1;
		chk({key.valid, r0.valid, r1.valid, irq, rdata}, 36'h0);
		@(posedge i_clk_sys);
		i_rst_n <= 1'b1;
		rchk(12'h6C0, 32'h0000_0000);
		rchk(12'h700, 32'h0000_0000);
		$display("reset test done");
	endtask : t_reset
	task automatic tally_and_finish();
		$display("Counts: %0d comparisons, %0d mismatches", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		#500_000;
		n_mismatch++;
		tally_and_finish();
	end
	initial begin
		repeat (6) @(posedge i_clk_sys);
		i_rst_n <= 1'b1;
		t_regs();
		t_class();
		t_fields();
		t_actions();
		t_disabled();
		t_single();
		t_reset();
		tally_and_finish();
	end
endmodule : egress_acl_key_action_bench
bind egress_acl_block_top eaka_props u_eaka_props (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
	.i_frame(i_frame), .i_hit(i_hit), .i_action0(i_action0), .i_action1(i_action1),
	.o_key(o_key), .o_result0(o_result0), .o_result1(o_result1), .o_hit_irq(o_hit_irq));
